// >>> shared/rfb_pkg.sv
`default_nettype none
package rfb_pkg;
    localparam int          FIFO_DEPTH     = 12;
    localparam int          PTR_W          = 4;
    localparam logic [3:0]  PTR_LAST       = 4'hB;
    localparam logic [3:0]  LEVEL_FULL     = 4'hC;
    localparam int          CMD_BIT        = 7;
    localparam int          READ_BIT       = 6;
    localparam int          CONT_BIT       = 5;
    localparam int          ADDR_MSB       = 4;
    localparam int          LO_NIB_MSB     = 7;
    localparam int          LO_NIB_LSB     = 4;
    localparam logic [4:0]  CMD_FIFO_RESET = 5'h0F;
    localparam logic [4:0]  CMD_TX_PLAIN   = 5'h10;
    localparam logic [4:0]  CMD_TX_CRC     = 5'h11;
    localparam logic [4:0]  ADDR_TX_LEN_HI = 5'h1D;
    localparam logic [4:0]  ADDR_TX_LEN_LO = 5'h1E;
    localparam logic [4:0]  ADDR_FIFO      = 5'h1F;
    localparam logic [7:0]  TX_LEN_HI_RST  = 8'h00;
    localparam logic [7:0]  TX_LEN_LO_RST  = 8'h00;

    typedef enum logic [1:0] {
        RFB_RX_PAYLOAD = 2'b00,
        RFB_RX_SOF     = 2'b01,
        RFB_RX_EOF     = 2'b10,
        RFB_RX_CRC     = 2'b11
    } rfb_rx_kind_t;

    typedef struct packed {
        rfb_rx_kind_t kind;
        logic [7:0]   data;
    } rfb_rx_sym_t;

    typedef struct packed {
        logic       start;
        logic       stop;
        logic       wr;
        logic       rd;
        logic [7:0] data;
    } rfb_host_in_t;

    typedef enum logic [1:0] {
        RFB_HS_IDLE = 2'b00,
        RFB_HS_CMD  = 2'b01,
        RFB_HS_DATA = 2'b10
    } rfb_hstate_t;
endpackage
`default_nettype wire

// >>> hdl/rfb_fifo.sv
`default_nettype none
// How it works
// [R01] One twelve-byte FIFO serves transmit and receive.
// [R02] Receive keeps payload, drops SOF, EOF, checksum.
// [R03] Host opens with start, then reset command.
// [R04] Command 0x90 plain, 0x91 appends checksum.
// [R05] Host writes continuously from length register.
// [R06] Length: high byte, then low nibble byte.
// [R07] Payload follows lengths, then stop condition.
// [R08] Transmission starts on first payload byte.
// [R09] Only continuous writes load the FIFO.
// [R10] Host reads FIFO only after tag reply; the code awaits no reply and blocks reads only while tx_busy or the FIFO is empty.
// [R11] Address bit7 direct command, bit5 continuous.
module rfb_fifo (
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire rfb_pkg::rfb_host_in_t host,
    output logic [7:0]                 host_rd_data,
    output logic                       host_rd_valid,
    input  wire logic                  rx_valid,
    input  wire rfb_pkg::rfb_rx_sym_t  rx_sym,
    input  wire logic                  tx_ready,
    output logic                       tx_valid,
    output logic [7:0]                 tx_data,
    output logic                       tx_start,
    output logic                       tx_crc,
    output logic                       tx_busy,
    output logic [11:0]                tx_byte_count,
    output logic [3:0]                 fifo_level,
    output logic                       fifo_full,
    output logic                       fifo_empty
);
    function automatic logic [3:0] ptr_inc(input logic [3:0] p);
        ptr_inc = (p == rfb_pkg::PTR_LAST) ? 4'h0 : p + 4'h1;
    endfunction

    rfb_pkg::rfb_hstate_t state_reg, state_next;
    logic [4:0]  addr_reg, addr_next;
    logic        cont_reg, cont_next;
    logic        rdm_reg, rdm_next;
    logic [7:0]  len_hi_reg, len_hi_next;
    logic [7:0]  len_lo_reg, len_lo_next;
    logic        crc_reg, crc_next;
    logic        armed_reg, armed_next;
    logic        start_reg, start_next;
    logic        busy_reg, busy_next;
    logic [11:0] sent_reg, sent_next;
    logic [7:0]  rdat_reg, rdat_next;
    logic        rval_reg, rval_next;
    logic [7:0]  mem_reg [rfb_pkg::FIFO_DEPTH];
    logic [7:0]  mem_next [rfb_pkg::FIFO_DEPTH];
    logic [3:0]  wp_reg, wp_next, rp_reg, rp_next, lvl_reg, lvl_next;

    logic       in_cmd, in_data, is_direct, fifo_clr, host_push, rx_push, push;
    logic       tx_pop, host_pop, pop;
    logic [4:0] code;
    logic [7:0] push_byte;

    assign in_cmd    = (state_reg == rfb_pkg::RFB_HS_CMD) && host.wr;
    assign in_data   = (state_reg == rfb_pkg::RFB_HS_DATA) && host.wr && !rdm_reg;
    assign is_direct = host.data[rfb_pkg::CMD_BIT]; // see [R11]
    assign code      = host.data[rfb_pkg::ADDR_MSB:0];
    assign fifo_clr  = in_cmd && is_direct && code == rfb_pkg::CMD_FIFO_RESET; // see [R03]
    // Host payload only enters through a continuous write aimed at the FIFO location.
    assign host_push = in_data && cont_reg && addr_reg == rfb_pkg::ADDR_FIFO
                       && !fifo_full; // see [R09]
    assign rx_push   = rx_valid && rx_sym.kind == rfb_pkg::RFB_RX_PAYLOAD
                       && !fifo_full && !host_push; // see [R02]
    assign push      = host_push || rx_push;
    assign push_byte = host_push ? host.data : rx_sym.data;
    assign tx_valid  = busy_reg && !fifo_empty;
    assign tx_pop    = tx_valid && tx_ready;
    // The transmitter owns the read side while busy; a host read then returns zero.
    assign host_pop  = (state_reg == rfb_pkg::RFB_HS_DATA) && host.rd && rdm_reg
                       && addr_reg == rfb_pkg::ADDR_FIFO && !busy_reg && !fifo_empty;
    assign pop       = tx_pop || host_pop;

    always_comb begin
        state_next = state_reg;
        addr_next  = addr_reg;
        cont_next  = cont_reg;
        rdm_next   = rdm_reg;
        len_hi_next = len_hi_reg;
        len_lo_next = len_lo_reg;
        crc_next   = crc_reg;
        armed_next = armed_reg;
        rdat_next  = rdat_reg;
        rval_next  = 1'b0;
        if (host.start) begin
            state_next = rfb_pkg::RFB_HS_CMD;
        end else if (host.stop) begin
            state_next = rfb_pkg::RFB_HS_IDLE;
        end else if (in_cmd) begin
            if (is_direct) begin
                if (code == rfb_pkg::CMD_TX_PLAIN || code == rfb_pkg::CMD_TX_CRC) begin
                    crc_next   = (code == rfb_pkg::CMD_TX_CRC); // see [R04]
                    armed_next = 1'b1;
                end
            end else begin
                addr_next  = code;
                cont_next  = host.data[rfb_pkg::CONT_BIT]; // see [R11]
                rdm_next   = host.data[rfb_pkg::READ_BIT];
                state_next = rfb_pkg::RFB_HS_DATA;
            end
        end else if (in_data) begin
            if (addr_reg == rfb_pkg::ADDR_TX_LEN_HI) begin
                len_hi_next = host.data; // see [R06]
            end
            if (addr_reg == rfb_pkg::ADDR_TX_LEN_LO) begin
                len_lo_next = host.data; // see [R06]
            end
            if (cont_reg && addr_reg != rfb_pkg::ADDR_FIFO) begin
                addr_next = addr_reg + 5'h01;
            end
        end else if ((state_reg == rfb_pkg::RFB_HS_DATA) && host.rd && rdm_reg) begin
            rval_next = 1'b1;
            unique case (addr_reg)
                rfb_pkg::ADDR_TX_LEN_HI: rdat_next = len_hi_reg;
                rfb_pkg::ADDR_TX_LEN_LO: rdat_next = len_lo_reg;
                rfb_pkg::ADDR_FIFO:      rdat_next = host_pop ? mem_reg[rp_reg] : 8'h00;
                default:                 rdat_next = 8'h00;
            endcase
            if (cont_reg && addr_reg != rfb_pkg::ADDR_FIFO) begin
                addr_next = addr_reg + 5'h01;
            end
        end
        if (fifo_clr) begin
            armed_next = 1'b0;
        end
        if (host_push && armed_reg) begin
            armed_next = 1'b0;
        end
    end

    always_comb begin
        start_next = host_push && armed_reg; // see [R08]
        busy_next  = busy_reg;
        sent_next  = sent_reg;
        if (start_reg) begin
            busy_next = 1'b1;
            sent_next = 12'h000;
        end else if (tx_pop) begin
            sent_next = sent_reg + 12'h001;
            if (sent_reg + 12'h001 >= tx_byte_count) begin
                busy_next = 1'b0;
            end
        end
        if (fifo_clr) begin
            busy_next = 1'b0;
        end
    end

    always_comb begin
        for (int i = 0; i < rfb_pkg::FIFO_DEPTH; i++) begin
            mem_next[i] = mem_reg[i];
        end
        wp_next  = wp_reg;
        rp_next  = rp_reg;
        lvl_next = lvl_reg;
        if (fifo_clr) begin
            wp_next  = 4'h0;
            rp_next  = 4'h0;
            lvl_next = 4'h0;
        end else begin
            if (push) begin
                mem_next[wp_reg] = push_byte; // see [R01]
                wp_next = ptr_inc(wp_reg);
            end
            if (pop) begin
                rp_next = ptr_inc(rp_reg);
            end
            lvl_next = lvl_reg + {3'h0, push} - {3'h0, pop};
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg  <= rfb_pkg::RFB_HS_IDLE;
            addr_reg   <= 5'h00;
            cont_reg   <= 1'b0;
            rdm_reg    <= 1'b0;
            len_hi_reg <= rfb_pkg::TX_LEN_HI_RST;
            len_lo_reg <= rfb_pkg::TX_LEN_LO_RST;
            crc_reg    <= 1'b0;
            armed_reg  <= 1'b0;
            start_reg  <= 1'b0;
            busy_reg   <= 1'b0;
            sent_reg   <= 12'h000;
            rdat_reg   <= 8'h00;
            rval_reg   <= 1'b0;
            wp_reg     <= 4'h0;
            rp_reg     <= 4'h0;
            lvl_reg    <= 4'h0;
            for (int i = 0; i < rfb_pkg::FIFO_DEPTH; i++) begin
                mem_reg[i] <= 8'h00;
            end
        end else begin
            state_reg  <= state_next;
            addr_reg   <= addr_next;
            cont_reg   <= cont_next;
            rdm_reg    <= rdm_next;
            len_hi_reg <= len_hi_next;
            len_lo_reg <= len_lo_next;
            crc_reg    <= crc_next;
            armed_reg  <= armed_next;
            start_reg  <= start_next;
            busy_reg   <= busy_next;
            sent_reg   <= sent_next;
            rdat_reg   <= rdat_next;
            rval_reg   <= rval_next;
            wp_reg     <= wp_next;
            rp_reg     <= rp_next;
            lvl_reg    <= lvl_next;
            for (int i = 0; i < rfb_pkg::FIFO_DEPTH; i++) begin
                mem_reg[i] <= mem_next[i];
            end
        end
    end

    assign host_rd_data  = rdat_reg;
    assign host_rd_valid = rval_reg;
    assign tx_data       = mem_reg[rp_reg];
    assign tx_start      = start_reg;
    assign tx_crc        = crc_reg;
    assign tx_busy       = busy_reg;
    assign tx_byte_count = {len_hi_reg, len_lo_reg[rfb_pkg::LO_NIB_MSB:rfb_pkg::LO_NIB_LSB]};
    assign fifo_level    = lvl_reg;
    assign fifo_full     = (lvl_reg == rfb_pkg::LEVEL_FULL);
    assign fifo_empty    = (lvl_reg == 4'h0);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_fifo_cap_bound: assert property (fifo_level <= rfb_pkg::LEVEL_FULL) // see [R01]
        else $error("FIFO level above twelve.");
    a_rx_strip_frame: assert property ( // see [R02]
        rx_valid && rx_sym.kind != rfb_pkg::RFB_RX_PAYLOAD && !host.wr && !pop && !fifo_clr
        |=> fifo_level == $past(fifo_level))
        else $error("Framing byte entered the FIFO.");
    a_tx_crc_select: assert property ( // see [R04]
        state_reg == rfb_pkg::RFB_HS_CMD && host.wr && !host.start && !host.stop
        && (host.data == 8'h90 || host.data == 8'h91)
        |=> tx_crc == $past(host.data[0]))
        else $error("Checksum option does not follow transmit command.");
    a_len_low_nib: assert property ( // see [R06]
        in_data && !host.start && !host.stop && addr_reg == rfb_pkg::ADDR_TX_LEN_LO
        |=> tx_byte_count[3:0] == $past(host.data[7:4]))
        else $error("Low nibble of count not taken from upper bits.");
    a_tx_first_byte: assert property ( // see [R08]
        host_push && armed_reg |=> tx_start ##1 tx_busy)
        else $error("Transmission did not start on first payload byte.");
    a_single_no_load: assert property ( // see [R09]
        in_data && !cont_reg && !rx_valid |=> fifo_level <= $past(fifo_level))
        else $error("Single write loaded the FIFO.");
    a_direct_stays_cmd: assert property ( // see [R11]
        in_cmd && is_direct && !host.start && !host.stop |=> state_reg == rfb_pkg::RFB_HS_CMD)
        else $error("Direct command left command state.");
    a_reset_cmd_empty: assert property ( // see [R03]
        in_cmd && host.data == 8'h8F |=> (fifo_empty && !tx_busy) [*2])
        else $error("Reset command did not empty the FIFO.");
endmodule
`default_nettype wire

// >>> sim/rfb_host_model.sv
`default_nettype none
module rfb_host_model (
    input  wire logic                  clk,
    output var  rfb_pkg::rfb_host_in_t host
);
    timeunit 1ns;
    timeprecision 1ns;

    initial host = '0;

    // Control nibble is {start, stop, wr, rd}; all change only at the falling edge.
    task automatic put(input logic [3:0] c, input logic [7:0] d);
        @(negedge clk);
        host = {c, d};
    endtask

    // An idle bus shows the inverted byte, so a stale value never looks like data.
    task automatic idle();
        put(4'h0, ~host.data);
    endtask

    task automatic frame(input logic crc, input logic [11:0] n, input int np);
        put(4'h8, 8'h00);
        put(4'h2, 8'h8F);
        put(4'h2, {7'h48, crc});
        put(4'h2, 8'h3D);
        put(4'h2, n[11:4]);
        put(4'h2, {n[3:0], 4'h0});
        for (int i = 0; i < np; i++) begin
            put(4'h2, 8'hA0 + i[7:0]);
        end
        put(4'h4, 8'h00);
        idle();
    endtask

    task automatic cmd2(input logic [7:0] a, input logic [7:0] d);
        put(4'h8, 8'h00);
        put(4'h2, a);
        put(4'h2, d);
        put(4'h4, 8'h00);
        idle();
    endtask

    // Reads are issued straight after the read address byte; no reply is awaited.
    task automatic read(input int nb);
        put(4'h8, 8'h00);
        put(4'h2, 8'h5F);
        for (int i = 0; i < nb; i++) begin
            put(4'h1, 8'h00);
        end
        put(4'h4, 8'h00);
        idle();
    endtask
endmodule
`default_nettype wire

// >>> sim/rfb_fifo_test.sv
`default_nettype none
module rfb_fifo_test;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int          NR = 5;
    localparam logic [12:0] ROW_CFG [NR] = '{13'h0001, 13'h1005, 13'h000C, 13'h1002, 13'h0012};
    localparam int          ROW_NP  [NR] = '{1, 5, 13, 4, 3};
    localparam int          ROW_LV  [NR] = '{1, 5, 12, 4, 3};
    localparam logic [9:0]  RX_SEQ  [6]  = '{10'h100, 10'h011, 10'h322, 10'h033, 10'h044, 10'h2AA};
    localparam logic [7:0]  RX_EXP  [3]  = '{8'h11, 8'h33, 8'h44};

    logic                  clk = 1'b0;
    logic                  arst_n = 1'b1;
    rfb_pkg::rfb_host_in_t host;
    logic [7:0]            host_rd_data;
    logic                  host_rd_valid;
    logic                  rx_valid = 1'b0;
    rfb_pkg::rfb_rx_sym_t  rx_sym = '0;
    logic                  tx_ready = 1'b0;
    logic                  tx_valid;
    logic [7:0]            tx_data;
    logic                  tx_start;
    logic                  tx_crc;
    logic                  tx_busy;
    logic [11:0]           tx_byte_count;
    logic [3:0]            fifo_level;
    logic                  fifo_full;
    logic                  fifo_empty;
    int                    mismatches = 0;
    int                    samples_checked = 0;
    int                    starts = 0;
    logic [3:0]            lvl_at_start = 4'h0;
    logic [7:0]            rd_q [$];
    int                    pops;

    always #50 clk = ~clk;

    always @(posedge clk) begin
        if (tx_start === 1'b1) begin
            starts++;
            lvl_at_start = fifo_level;
        end
        if (host_rd_valid === 1'b1) begin
            rd_q.push_back(host_rd_data);
        end
    end

    rfb_host_model host_u (.clk(clk), .host(host));

    rfb_fifo dut_u (.clk(clk), .arst_n(arst_n), .host(host), .host_rd_data(host_rd_data),
        .host_rd_valid(host_rd_valid), .rx_valid(rx_valid), .rx_sym(rx_sym),
        .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_start(tx_start),
        .tx_crc(tx_crc), .tx_busy(tx_busy), .tx_byte_count(tx_byte_count),
        .fifo_level(fifo_level), .fifo_full(fifo_full), .fifo_empty(fifo_empty));

    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [11:0] e, input logic [11:0] s, input string n);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wait_busy(input logic e);
        for (int i = 0; i < 4 && tx_busy !== e; i++) begin
            @(negedge clk);
        end
        chk(e, tx_busy, "tx_busy");
        if (tx_busy !== e) begin
            summarize();
        end
    endtask

    initial begin
        // A real falling edge is needed: an initial low level would only apply the reset at the first rising clock edge.
        #1;
        arst_n = 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        chk(1, fifo_empty, "fifo_empty");
        chk(0, {tx_busy, fifo_full, fifo_level}, "reset_state");
        for (int r = 0; r < NR; r++) begin
            host_u.frame(ROW_CFG[r][12], ROW_CFG[r][11:0], ROW_NP[r]);
            chk(ROW_CFG[r][12], tx_crc, "tx_crc");
            chk(ROW_CFG[r][11:0], tx_byte_count, "tx_byte_count");
            chk(ROW_LV[r], fifo_level, "fifo_level");
            chk(ROW_LV[r] == 12, fifo_full, "fifo_full");
            chk(r + 1, starts, "tx_start_count");
            chk(1, lvl_at_start, "level_at_start");
            pops = (ROW_CFG[r][11:0] < ROW_LV[r]) ? ROW_CFG[r][11:0] : ROW_LV[r];
            for (int k = 0; k < pops; k++) begin
                chk(8'hA0 + k, tx_data, "tx_data");
                chk(1, tx_valid, "tx_valid");
                tx_ready = 1'b1;
                @(negedge clk);
            end
            tx_ready = 1'b0;
            wait_busy(ROW_CFG[r][11:0] > ROW_LV[r]);
            chk(ROW_LV[r] - pops, fifo_level, "level_after");
            chk(0, tx_valid, "tx_valid_idle");
        end
        host_u.cmd2(8'h8F, 8'h8F);
        wait_busy(1'b0);
        chk(1, fifo_empty, "fifo_empty_reset");
        host_u.cmd2(8'h1F, 8'h55);
        chk(0, fifo_level, "single_write");
        for (int i = 0; i < 6; i++) begin
            @(negedge clk);
            rx_valid = 1'b1;
            rx_sym = RX_SEQ[i];
        end
        @(negedge clk);
        rx_valid = 1'b0;
        @(negedge clk);
        chk(3, fifo_level, "rx_level");
        host_u.read(3);
        @(negedge clk);
        chk(3, rd_q.size(), "rd_count");
        for (int i = 0; i < 3 && i < rd_q.size(); i++) begin
            chk(RX_EXP[i], rd_q[i], "rd_data");
        end
        chk(1, fifo_empty, "fifo_empty_read");
        // Reset in mid-run, while a long transmission is still waiting for bytes.
        host_u.frame(1'b1, 12'h012, 3);
        chk(12'h063, {tx_busy, tx_crc, tx_start, fifo_level}, "pre_reset");
        arst_n = 1'b0;
        @(negedge clk);
        chk(12'h001, {tx_busy, tx_crc, tx_start, fifo_level, fifo_empty}, "in_reset");
        chk(12'h000, tx_byte_count, "count_in_reset");
        arst_n = 1'b1;
        repeat (2) @(negedge clk);
        chk(12'h001, {tx_busy, tx_crc, tx_start, fifo_level, fifo_empty}, "after_reset");
        chk(12'h000, {host_rd_valid, tx_valid, fifo_full}, "flags_after_reset");
        chk(12'h000, tx_byte_count, "count_after_reset");
        summarize();
    end
endmodule
`default_nettype wire
